//--- inc/rcmr_pkg.sv
// Purpose: Shared constants for the reset cause and memory remap block.
// Assumes: 32-bit AHB-Lite register bus, one word per register.
// Notes: Offsets are byte addresses on the bus.
`default_nettype none
package rcmr_pkg;
	// ==========================================================
	// Register map
	localparam logic [31:0] MAP_CTRL_ADDR = 32'hFFFF0220;
	localparam logic [31:0] CAUSE_FLAGS_ADDR = 32'hFFFF0230;
	localparam logic [31:0] CAUSE_CLEAR_ADDR = 32'hFFFF0234;
	localparam int REG_W = 8;
	localparam logic [7:0] CAUSE_FLAGS_RST = 8'h01;
	localparam logic [7:0] CAUSE_CLEAR_RST = 8'h00;
	localparam logic [7:0] MAP_CTRL_RST = 8'h00;
	// ==========================================================
	// Field positions
	localparam int MAP_SRAM_BIT = 0;
	localparam int MAP_SRAM4K_BIT = 3;
	localparam int MAP_FLASH32K_BIT = 4;
	localparam int CAUSE_POR_BIT = 0;
	localparam int CAUSE_WDT_BIT = 1;
	localparam int CAUSE_SOFT_BIT = 2;
	localparam logic [7:0] CAUSE_USED_MASK = 8'h07;
	// ==========================================================
	// Address map of the low alias
	localparam logic [31:0] ALIAS_BASE = 32'h00000000;
	localparam logic [31:0] ALIAS_LAST = 32'h00000020;
	localparam logic [31:0] FLASH_BASE = 32'h00080000;
	localparam logic [31:0] SRAM_BASE = 32'h00010000;
	localparam logic [31:0] RESET_VECTOR = 32'h00000000;
	// ==========================================================
	// Timing
	localparam int KERNEL_TIME_NS = 320;
	localparam int CLK_PERIOD_NS = 20;
	localparam int KERNEL_CYCLES =
		(KERNEL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// ==========================================================
	// Bus encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic HRESP_OKAY = 1'h0;
	// ==========================================================
	// Boot sequencer states
	typedef enum logic [2:0] {
		ST_KERNEL = 3'h1,
		ST_USER = 3'h2,
		ST_HOLD = 3'h4
	} rcmr_boot_t;

	function automatic logic reg_hit(input logic [31:0] a,
		input logic [31:0] off);
		reg_hit = (a[31:2] == off[31:2]);
	endfunction : reg_hit
endpackage : rcmr_pkg
`default_nettype wire

//--- inc/rcmr_map_if.sv
// Purpose: Carries alias lookups between the top and the decoder.
// Assumes: One lookup per cycle, answered one cycle later.
// Notes: The top drives the request side and the map selection.
`default_nettype none
interface rcmr_map_if;
	logic sram_sel;
	logic req_valid;
	logic [31:0] req_addr;
	logic rsp_valid;
	logic rsp_sram;
	logic [31:0] rsp_addr;
	modport top (
		output sram_sel,
		output req_valid,
		output req_addr,
		input rsp_valid,
		input rsp_sram,
		input rsp_addr
	);
	modport decoder (
		input sram_sel,
		input req_valid,
		input req_addr,
		output rsp_valid,
		output rsp_sram,
		output rsp_addr
	);
endinterface : rcmr_map_if
`default_nettype wire

//--- core/rcmr_alias.sv
// Purpose: Translates low addresses to flash or SRAM physical space.
// Assumes: Map selection is stable while a lookup is in flight.
// Notes: Answer is registered, one cycle after the request.
`default_nettype none
module rcmr_alias (
	input wire logic clk,
	input wire logic rst,
	rcmr_map_if.decoder map
);
	// ==========================================================
	// Lookup
	wire logic in_alias;
	wire logic to_sram;
	wire logic [31:0] phys_d;

	// Only the vector window is mirrored; everything else passes.
	assign in_alias = (map.req_addr <= rcmr_pkg::ALIAS_LAST);
	assign to_sram = in_alias && map.sram_sel;
	assign phys_d = !in_alias ? map.req_addr :
		to_sram ? (rcmr_pkg::SRAM_BASE | map.req_addr) :
		(rcmr_pkg::FLASH_BASE | map.req_addr);

	logic rsp_valid_q;
	logic rsp_sram_q;
	logic [31:0] rsp_addr_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rsp_valid_q <= 1'h0;
			rsp_sram_q <= 1'h0;
			rsp_addr_q <= 32'h00000000;
		end else begin
			rsp_valid_q <= map.req_valid;
			rsp_sram_q <= to_sram;
			rsp_addr_q <= phys_d;
		end
	end

	assign map.rsp_valid = rsp_valid_q;
	assign map.rsp_sram = rsp_sram_q;
	assign map.rsp_addr = rsp_addr_q;
endmodule : rcmr_alias
`default_nettype wire

//--- core/rcmr_top.sv
// Purpose: Reset cause recording, boot sequencing and low memory remap.
// Assumes: rst is asserted for every reset kind; por only at power-on.
// Notes: Registers sit on an AHB-Lite slave with zero wait states.
//
// What this block does
// - After any reset, flash is mirrored at address zero.
// - The mirrored region covers vectors from 0x00000000 to 0x00000020.
// - Writing one to map bit 0 mirrors SRAM at address zero.
// - Clearing map bit 0 restores the flash mirror, at any time.
// - Every reset clears the SRAM-at-zero selection.
// - Reset starts the hidden kernel, then boot pin high jumps to zero.
// - Map bit 4 is read-only, one when only 32 kB flash exists.
// - Map bit 3 read-only, one for 4 kB SRAM; bits 2:1 reserved.
// - Four reset sources; the cause register keeps every flag set since the last clear.
// - A cause register of all zeros means an external reset.
// - Power-on reset sets cause bit 0, reset value 0x01.
// - Watchdog expiry sets cause bit 1 and resets the device.
// - Writing one to cause bit 2 forces a reset, bit stays set.
// - Cause flags clear only through the clear register, bits 7:3 reserved.
//
// Added by the designer: the AHB-Lite register port.
`default_nettype none
module rcmr_top #(
	parameter logic FLASH_SMALL = 1'h0,
	parameter logic SRAM_SMALL = 1'h0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic por,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic wdt_expire,
	input wire logic boot_mode_pin,
	input wire logic fetch_valid,
	input wire logic [31:0] fetch_addr,
	output logic fetch_rsp_valid,
	output logic fetch_rsp_sram,
	output logic [31:0] fetch_rsp_addr,
	output logic sys_reset_req,
	output logic kernel_active,
	output logic core_run,
	output logic [31:0] core_start_addr
);
	// ==========================================================
	// Bus address phase
	wire logic take;
	wire logic take_word;
	wire logic hit_map;
	wire logic hit_flags;
	wire logic hit_clear;

	assign take = hsel && hready && (htrans == rcmr_pkg::HTRANS_NONSEQ);
	assign take_word = take && (hsize == rcmr_pkg::HSIZE_WORD);
	assign hit_map = rcmr_pkg::reg_hit(haddr, rcmr_pkg::MAP_CTRL_ADDR);
	assign hit_flags = rcmr_pkg::reg_hit(haddr, rcmr_pkg::CAUSE_FLAGS_ADDR);
	assign hit_clear = rcmr_pkg::reg_hit(haddr, rcmr_pkg::CAUSE_CLEAR_ADDR);

	logic wr_map_q;
	logic wr_flags_q;
	logic wr_clear_q;
	logic wr_map_d;
	logic wr_flags_d;
	logic wr_clear_d;

	// Byte and halfword writes are dropped so that no lane is half applied.
	assign wr_map_d = take_word && hwrite && hit_map;
	assign wr_flags_d = take_word && hwrite && hit_flags;
	assign wr_clear_d = take_word && hwrite && hit_clear;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_map_q <= 1'h0;
			wr_flags_q <= 1'h0;
			wr_clear_q <= 1'h0;
		end else begin
			wr_map_q <= wr_map_d;
			wr_flags_q <= wr_flags_d;
			wr_clear_q <= wr_clear_d;
		end
	end

	// ==========================================================
	// Memory map control
	logic sram_sel_q;
	wire logic sram_sel_d;
	wire logic [7:0] map_view;

	assign sram_sel_d = wr_map_q ? hwdata[rcmr_pkg::MAP_SRAM_BIT] :
		sram_sel_q;

	// Any reset lands here, so flash always owns address zero after it.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sram_sel_q <= rcmr_pkg::MAP_CTRL_RST[rcmr_pkg::MAP_SRAM_BIT];
		end else begin
			sram_sel_q <= sram_sel_d;
		end
	end

	// Size bits come from the model straps and ignore writes.
	assign map_view = {3'h0, FLASH_SMALL, SRAM_SMALL, 2'h0, sram_sel_q};

	// ==========================================================
	// Reset cause flags
	logic [7:0] flags_q;
	wire logic [7:0] flags_d;
	wire logic [7:0] flag_set;
	wire logic [7:0] flag_clr;
	wire logic soft_req;

	assign soft_req = wr_flags_q && hwdata[rcmr_pkg::CAUSE_SOFT_BIT];
	assign flag_set = {5'h00, soft_req, wdt_expire, 1'h0};
	// Only ones in the clear word act; zeros leave the flag alone.
	assign flag_clr = wr_clear_q ?
		(hwdata[7:0] & rcmr_pkg::CAUSE_USED_MASK) : 8'h00;
	// A new cause arriving with a clear is kept: set beats clear.
	assign flags_d = (flags_q & ~flag_clr) | flag_set;

	// Flags survive every reset but power-on, so software can read them
	// in its reset handler; an untouched all-zero word means external.
	always_ff @(posedge clk or posedge por) begin
		if (por) begin
			flags_q <= rcmr_pkg::CAUSE_FLAGS_RST;
		end else begin
			flags_q <= flags_d;
		end
	end

	// ==========================================================
	// Reset cause clear register
	logic [7:0] clear_q;
	wire logic [7:0] clear_d;

	assign clear_d = wr_clear_q ?
		(hwdata[7:0] & rcmr_pkg::CAUSE_USED_MASK) : clear_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			clear_q <= rcmr_pkg::CAUSE_CLEAR_RST;
		end else begin
			clear_q <= clear_d;
		end
	end

	// ==========================================================
	// Reset request to the system reset generator
	logic sys_reset_req_q;
	wire logic sys_reset_req_d;

	assign sys_reset_req_d = wdt_expire || soft_req;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sys_reset_req_q <= 1'h0;
		end else begin
			sys_reset_req_q <= sys_reset_req_d;
		end
	end

	// ==========================================================
	// Boot sequencer
	rcmr_pkg::rcmr_boot_t state_q;
	rcmr_pkg::rcmr_boot_t state_d;
	logic [7:0] kcount_q;
	logic [7:0] kcount_d;
	wire logic kernel_done;

	assign kernel_done =
		(kcount_q == 8'(rcmr_pkg::KERNEL_CYCLES - 1));

	always_comb begin
		state_d = state_q;
		kcount_d = kcount_q;
		case (state_q)
			rcmr_pkg::ST_KERNEL: begin
				kcount_d = kcount_q + 8'h01;
				if (kernel_done) begin
					kcount_d = kcount_q;
					// A low boot pin parks the core in the kernel loader.
					state_d = boot_mode_pin ? rcmr_pkg::ST_USER :
						rcmr_pkg::ST_HOLD;
				end
			end
			rcmr_pkg::ST_USER: begin
				state_d = rcmr_pkg::ST_USER;
			end
			rcmr_pkg::ST_HOLD: begin
				state_d = rcmr_pkg::ST_HOLD;
			end
			default: begin
				state_d = rcmr_pkg::ST_KERNEL;
				kcount_d = 8'h00;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= rcmr_pkg::ST_KERNEL;
			kcount_q <= 8'h00;
		end else begin
			state_q <= state_d;
			kcount_q <= kcount_d;
		end
	end

	logic kernel_active_q;
	logic core_run_q;
	logic [31:0] core_start_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			kernel_active_q <= 1'h1;
			core_run_q <= 1'h0;
			core_start_q <= 32'h00000000;
		end else begin
			kernel_active_q <= (state_d != rcmr_pkg::ST_USER);
			core_run_q <= (state_d == rcmr_pkg::ST_USER);
			core_start_q <= rcmr_pkg::RESET_VECTOR;
		end
	end

	// ==========================================================
	// Alias decoder
	rcmr_map_if map_bus ();

	assign map_bus.sram_sel = sram_sel_q;
	assign map_bus.req_valid = fetch_valid;
	assign map_bus.req_addr = fetch_addr;

	// Software must move the map from code above the mirror; the
	// decoder does not hold off a switch under a running fetch.
	rcmr_alias rcmr_alias_i (
		.clk(clk),
		.rst(rst),
		.map(map_bus.decoder)
	);

	// ==========================================================
	// Bus data phase
	logic [31:0] hrdata_q;
	logic hreadyout_q;
	logic hresp_q;
	wire logic [7:0] rd_sel;

	// Read data is fetched at the address phase from the current state.
	assign rd_sel = hit_map ? map_view :
		hit_flags ? flags_q :
		hit_clear ? clear_q : 8'h00;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hrdata_q <= 32'h00000000;
			hreadyout_q <= 1'h1;
			hresp_q <= rcmr_pkg::HRESP_OKAY;
		end else begin
			hrdata_q <= (take && !hwrite) ? {24'h000000, rd_sel} : 32'h00000000;
			hreadyout_q <= 1'h1;
			hresp_q <= rcmr_pkg::HRESP_OKAY;
		end
	end

	// ==========================================================
	// Outputs
	assign hreadyout = hreadyout_q;
	assign hresp = hresp_q;
	assign hrdata = hrdata_q;
	assign sys_reset_req = sys_reset_req_q;
	assign kernel_active = kernel_active_q;
	assign core_run = core_run_q;
	assign core_start_addr = core_start_q;
	assign fetch_rsp_valid = map_bus.rsp_valid;
	assign fetch_rsp_sram = map_bus.rsp_sram;
	assign fetch_rsp_addr = map_bus.rsp_addr;
endmodule : rcmr_top
`default_nettype wire

//--- verif/rcmr_props.sv
// Purpose: Port-level checks on the reset cause and remap block.
// Assumes: Zero wait-state bus; write takes effect after its data phase.
// Notes: A shadow of the remap bit is rebuilt from bus writes.
`default_nettype none
module rcmr_props #(
	parameter logic FLASH_SMALL = 1'h0,
	parameter logic SRAM_SMALL = 1'h0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic wdt_expire,
	input wire logic boot_mode_pin,
	input wire logic fetch_valid,
	input wire logic [31:0] fetch_addr,
	input wire logic fetch_rsp_valid,
	input wire logic fetch_rsp_sram,
	input wire logic [31:0] fetch_rsp_addr,
	input wire logic sys_reset_req,
	input wire logic kernel_active,
	input wire logic core_run,
	input wire logic [31:0] core_start_addr
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// Bus phase tracking
	logic ph_q, w_q, m_q;
	logic [31:0] a_q;
	wire logic map_ph = ph_q && a_q == rcmr_pkg::MAP_CTRL_ADDR;
	wire logic flg_ph = ph_q && a_q == rcmr_pkg::CAUSE_FLAGS_ADDR;
	wire logic low = fetch_addr <= rcmr_pkg::ALIAS_LAST;
	wire logic [31:0] base = m_q ? rcmr_pkg::SRAM_BASE : rcmr_pkg::FLASH_BASE;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			{ph_q, w_q, m_q} <= 3'h0;
			a_q <= 32'h0;
		end else begin
			ph_q <= hsel && hready && htrans == rcmr_pkg::HTRANS_NONSEQ;
			w_q <= hwrite;
			a_q <= haddr;
			if (map_ph && w_q)
				m_q <= hwdata[0];
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_alias_low: assert property (fetch_valid && low |=> fetch_rsp_sram ==
		$past(m_q) && fetch_rsp_addr == ($past(base) | $past(fetch_addr)))
		else $error("low fetch went to the wrong memory");
	a_alias_pass: assert property (fetch_valid && !low |=> !fetch_rsp_sram &&
		fetch_rsp_addr == $past(fetch_addr)) else $error("high fetch altered");
	a_rsp_pulse: assert property (fetch_rsp_valid == $past(fetch_valid))
		else $error("fetch answer not one cycle after request");
	a_map_read: assert property (map_ph && !w_q |-> hrdata ==
		{27'h0, FLASH_SMALL, SRAM_SMALL, 2'h0, m_q}) else $error("map readback");
	a_flags_resv: assert property (flg_ph && !w_q |-> hrdata[31:3] == 29'h0)
		else $error("reserved cause bits set");
	a_wdt_req: assert property (wdt_expire |=> sys_reset_req)
		else $error("watchdog expiry gave no reset request");
	a_soft_req: assert property (flg_ph && w_q && hwdata[2] |=> sys_reset_req)
		else $error("software reset not requested");
	a_boot_hold: assert property ($fell(rst) |-> (kernel_active && !core_run)[*8])
		else $error("user code ran before the kernel finished");
	a_start_zero: assert property (core_run |-> core_start_addr == 32'h0)
		else $error("start address not zero");
	// The kernel must take its full time before user code is let go.
	a_run_time: assert property ($fell(rst) ##15 boot_mode_pin |->
		!core_run ##1 core_run) else $error("kernel length wrong");
	c_hold: cover property ($fell(rst) ##15 !boot_mode_pin);
	c_sram: cover property (fetch_valid && low && m_q);
	c_soft: cover property (flg_ph && w_q && hwdata[2]);
	c_wdt: cover property (wdt_expire);
endmodule : rcmr_props
bind rcmr_top rcmr_props #(.FLASH_SMALL(FLASH_SMALL), .SRAM_SMALL(SRAM_SMALL))
	rcmr_props_i (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hwdata,
	.hready, .hrdata, .wdt_expire, .boot_mode_pin, .fetch_valid,
	.fetch_addr, .fetch_rsp_valid, .fetch_rsp_sram, .fetch_rsp_addr,
	.sys_reset_req, .kernel_active, .core_run, .core_start_addr);
`default_nettype wire

//--- verif/rcmr_rst_model.sv
// Purpose: System reset controller beside the block.
// Assumes: A reset request is a one-cycle pulse.
// Notes: Three cycles of reset keep the async path well exercised.
`default_nettype none
module rcmr_rst_model (
	input wire logic clk,
	input wire logic sys_reset_req,
	output logic rst_req
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// Reset stretcher
	logic [1:0] cnt_q = 2'h0;
	always_ff @(posedge clk) begin
		if (sys_reset_req)
			cnt_q <= 2'h3;
		else if (cnt_q != 2'h0)
			cnt_q <= cnt_q - 2'h1;
	end
	assign rst_req = cnt_q != 2'h0;
endmodule : rcmr_rst_model
`default_nettype wire

//--- verif/reset_cause_and_memory_remap_test.sv
// Purpose: Self-checking bench for the reset cause and remap block.
// Assumes: Zero wait-state slave; the reset model restarts the block.
// Notes: Fetch expectations come from a bench function.
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
	err_count++; $display("wrong value at %0t got %h", $time, a); end end
module reset_cause_and_memory_remap_test;
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// Signals
	localparam logic [31:0] MAP = rcmr_pkg::MAP_CTRL_ADDR;
	localparam logic [31:0] FLG = rcmr_pkg::CAUSE_FLAGS_ADDR;
	localparam logic [31:0] CLR = rcmr_pkg::CAUSE_CLEAR_ADDR;
	logic clk, rst_tb, por, hsel, hwrite, wdt_expire, boot_mode_pin;
	logic fetch_valid;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, fetch_addr, q;
	wire logic rst, rst_req, hready, hresp, fetch_rsp_valid, fetch_rsp_sram;
	wire logic sys_reset_req, kernel_active, core_run;
	wire logic [31:0] hrdata, fetch_rsp_addr, core_start_addr;
	int err_count = 0;
	int samples_checked = 0;
	int seed = 76;
	assign rst = rst_tb | rst_req;
	rcmr_top #(.FLASH_SMALL(1'h1), .SRAM_SMALL(1'h1)) rcmr_top_i (
		.clk, .rst, .por, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hreadyout(hready), .hresp, .hrdata, .wdt_expire,
		.boot_mode_pin, .fetch_valid, .fetch_addr, .fetch_rsp_valid,
		.fetch_rsp_sram, .fetch_rsp_addr, .sys_reset_req, .kernel_active,
		.core_run, .core_start_addr);
	rcmr_rst_model rcmr_rst_model_i (.clk, .sys_reset_req, .rst_req);
	function automatic logic [33:0] lk(input logic [31:0] a, input logic s);
		if (a > rcmr_pkg::ALIAS_LAST)
			return {2'h2, a};
		return {1'h1, s,
			a | (s ? rcmr_pkg::SRAM_BASE : rcmr_pkg::FLASH_BASE)};
	endfunction : lk
	task automatic bus(input logic w, input logic [31:0] a, d);
		@(posedge clk);
		hsel <= 1'h1;
		htrans <= rcmr_pkg::HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'h1);
		q = hrdata;
		`CHK(hresp, rcmr_pkg::HRESP_OKAY)
	endtask : bus
	task automatic wr(input logic [31:0] a, d);
		bus(1'h1, a, d);
	endtask : wr
	task automatic rd(input logic [31:0] a, e);
		bus(1'h0, a, 32'h0);
		`CHK(q, e)
	endtask : rd
	task automatic looks(input logic s);
		logic [31:0] a;
		for (int i = 0; i < 6; i++) begin
			a = i == 0 ? 32'h20 : i == 1 ? 32'h24 : $random(seed) & 32'h3F;
			@(posedge clk);
			fetch_valid <= 1'h1;
			fetch_addr <= a;
			@(posedge clk);
			fetch_valid <= 1'h0;
			@(negedge clk);
			`CHK({fetch_rsp_valid, fetch_rsp_sram, fetch_rsp_addr}, lk(a, s))
		end
	endtask : looks
	task automatic boot();
		repeat (4) @(posedge clk);
		for (int i = 0; i < 100 && core_run !== 1'h1; i++)
			@(posedge clk);
		@(negedge clk);
		`CHK(core_run, 1'h1)
		`CHK(core_start_addr, rcmr_pkg::RESET_VECTOR)
	endtask : boot
	// An external reset never touches por, so the cause flags must stay.
	task automatic ext_rst(input logic pin);
		@(posedge clk);
		boot_mode_pin <= pin;
		rst_tb <= 1'h1;
		repeat (3) @(posedge clk);
		rst_tb <= 1'h0;
	endtask : ext_rst
	task automatic done(input string s);
		$display("test %0s done", s);
	endtask : done
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : finish_test
	// ==========================================================
	// Sequence
	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end
	initial begin
		#200000;
		err_count++;
		finish_test();
	end
	initial begin
		{rst_tb, por, boot_mode_pin} = 3'h7;
		{hsel, hwrite, wdt_expire, fetch_valid} = 4'h0;
		htrans = 2'h0;
		hsize = rcmr_pkg::HSIZE_WORD;
		{haddr, hwdata, fetch_addr} = 96'h0;
		repeat (8) @(posedge clk);
		rst_tb <= 1'h0;
		por <= 1'h0;
		boot();
		rd(MAP, 32'h18);
		rd(FLG, 32'h01);
		rd(CLR, 32'h00);
		rd(32'hFFFF0224, 32'h00);
		looks(1'h0);
		done("reset");
		wr(MAP, 32'hFF);
		rd(MAP, 32'h19);
		looks(1'h1);
		wr(MAP, 32'h00);
		looks(1'h0);
		done("remap");
		wr(CLR, 32'h00);
		rd(FLG, 32'h01);
		wr(CLR, 32'h07);
		rd(FLG, 32'h00);
		rd(CLR, 32'h07);
		done("clear");
		wr(MAP, 32'h01);
		ext_rst(1'h0);
		repeat (40) @(posedge clk);
		@(negedge clk);
		`CHK(core_run, 1'h0)
		`CHK(kernel_active, 1'h1)
		rd(FLG, 32'h00);
		rd(MAP, 32'h18);
		rd(CLR, 32'h00);
		ext_rst(1'h1);
		boot();
		done("external");
		wr(MAP, 32'h01);
		@(posedge clk);
		wdt_expire <= 1'h1;
		@(posedge clk);
		wdt_expire <= 1'h0;
		boot();
		rd(FLG, 32'h02);
		rd(MAP, 32'h18);
		done("watchdog");
		wr(FLG, 32'h04);
		boot();
		rd(FLG, 32'h06);
		done("software");
		finish_test();
	end
endmodule : reset_cause_and_memory_remap_test
`default_nettype wire
